// ---- panel_side_model.sv ----
// Purpose: panel side sync source with a free-running panel clock
// Assumes: a line is LINE panel clocks and a frame is FRAME lines
// Notes: syncs move on the falling panel edge so rising-edge sampling sees them settled
`timescale 1ns/100ps
module panel_side_model #(
  parameter int LINE = 40,
  parameter int FRAME = 6
) (
  output logic panel_clk,
  output logic hsync_in,
  output logic vsync_in
);
  int px = 0;
  int ln = 0;

  // 64 ns panel clock, phase unrelated to the bus clock; a panel clock never stops
  initial begin
    panel_clk = 1'b0;
    #7.3;
    forever #32 panel_clk = ~panel_clk;
  end

  // pixel and line counters
  always @(negedge panel_clk) begin
    px <= (px == LINE - 1) ? 0 : px + 1;
    if (px == LINE - 1) begin
      ln <= (ln == FRAME - 1) ? 0 : ln + 1;
    end
  end

  // one-clock syncs at the head of each line and frame
  assign hsync_in = (px == 0);
  assign vsync_in = (px == 0) && (ln == 0);
endmodule

// ---- panel_timing_params.svh ----
// Purpose: register offsets, field positions and reset values of the panel timing block
// Assumes: byte addresses on a 12-bit APB address, one 32-bit word per register
// Notes: definitions only
`ifndef PANEL_TIMING_PARAMS_SVH
`define PANEL_TIMING_PARAMS_SVH

// register byte addresses
`define HALF_LINE_ADDR 12'h000
`define OFFSET_HS_ADDR 12'h004
`define LINE_CMP_ADDR 12'h008
`define IRQ_STATUS_ADDR 12'h00c
`define IRQ_ENABLE_ADDR 12'h010
`define LINE_POS_ADDR 12'h014
`define SIG_BASE_ADDR 12'h020
`define SIG_SPAN 12'h040

// timing word of each signal
`define START_LSB 0
`define WIDTH_LSB 16
// control word of each signal
`define MODE_LSB 0
`define REFSEL_BIT 2
`define INV_BIT 3
`define PIN_LSB 4
`define EDGE_BIT 8

// reset values
`define COUNT_RESET 11'h000
`define PIN_NONE 4'hf
`define IRQ_RESET 4'h0

`endif

// ---- panel_timing_pkg.sv ----
// Purpose: shared types of the panel timing block
// Assumes: nothing
// Notes: per-signal configuration travels as one packed struct
package panel_timing_pkg;

  // configuration of one timing signal
  typedef struct packed {
    logic [10:0] start;
    logic [10:0] width;
    logic [1:0] mode;
    logic refsel;
    logic inv;
    logic [3:0] pin;
    logic fall_edge;
  } sig_cfg_t;

  // sequence of one pulse generator
  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_WAIT = 3'b010,
    PS_PULSE = 3'b100
  } pulse_state_t;

endpackage

// ---- panel_timing_signal_gen.sv ----
// Purpose: panel drive timing generator with eight programmable signals and line interrupts
// Assumes: panel_clk, hsync_in and vsync_in are pins, sampled by pclk well above their rate
// Notes: APB3 slave, zero wait states; unmapped addresses answer with pslverr
//
// How it works
// - each signal other than the data enable starts its pulse a programmable 11-bit count after its reference edge.
// - each signal other than polarity a/b stays active for a programmable 11-bit width count.
// - polarity signals flip every line, first line then every second, or every second line.
// - a select bit picks the normal or the offset horizontal sync as reference.
// - an inversion bit turns each signal from active high to active low.
// - each signal is routed to one of seven timing pins or to none.
// - each signal launches on the rising or the falling panel clock edge as selected.
// - the data enable ignores the start setting and other fields it does not use.
// - a line interrupt is raised when the line position equals the programmed line.
// - the line compare value serves only the four line-type interrupts.
// - each interrupt source has its own enable that gates its delivery.
// - the offset horizontal sync follows the normal one by a programmable 11-bit count.
// - eight generators cover vertical a/b, horizontal start, strobe, gate clock, polarity a/b, data enable.
`timescale 1ns/100ps
`include "panel_timing_params.svh"
module panel_timing_signal_gen
  import panel_timing_pkg::*;
#(
  parameter int NUM_SIG = 8,
  parameter int NUM_PIN = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic panel_clk,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic [10:0] scaler0_line,
  input wire logic [10:0] scaler1_line,
  input wire logic [10:0] out_image_line,
  output logic [6:0] panel_timing_out_pin,
  output logic irq
);

  if (NUM_SIG != 8 || NUM_PIN != 7) begin : g_bad_count
    $error("the block serves exactly eight signals and seven pins");
  end

  // signal indices
  localparam int SIG_POL_A = 5;
  localparam int SIG_POL_B = 6;
  localparam int SIG_DE = 7;

  sig_cfg_t cfg [NUM_SIG];
  sig_cfg_t next_cfg [NUM_SIG];
  logic [10:0] half_cnt, next_half_cnt;
  logic [10:0] offset_cnt, next_offset_cnt;
  logic [10:0] line_cmp, next_line_cmp;
  logic [3:0] irq_status, next_irq_status;
  logic [3:0] irq_enable, next_irq_enable;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [3:0] line_ev;

  // pin synchronisers: {vsync, hsync, panel clock}
  logic [2:0] sync1, sync2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {vsync_in, hsync_in, panel_clk};
      sync2 <= sync1;
    end
  end

  // edge finding on the synchronised pins
  logic clk_last, hs_last, vs_last;
  logic next_clk_last, next_hs_last, next_vs_last;
  logic p_rise, p_fall, hs_rise, vs_rise;
  always_comb begin
    p_rise = sync2[0] & ~clk_last;
    p_fall = ~sync2[0] & clk_last;
    hs_rise = p_rise & sync2[1] & ~hs_last;
    vs_rise = p_rise & sync2[2] & ~vs_last;
    next_clk_last = sync2[0];
    next_hs_last = p_rise ? sync2[1] : hs_last;
    next_vs_last = p_rise ? sync2[2] : vs_last;
  end

  // horizontal position in panel clocks since the normal sync
  logic [10:0] hcnt, next_hcnt, pos;
  logic pos_valid, off_ev, half_ev;
  logic [10:0] line_pos, next_line_pos;
  logic [1:0] vpend, next_vpend;
  logic [1:0] vref;
  always_comb begin
    pos = hs_rise ? 11'h000 : ((hcnt == 11'h7ff) ? hcnt : hcnt + 11'h001);
    pos_valid = hs_rise | (hcnt != 11'h7ff);
    off_ev = p_rise & pos_valid & (pos == offset_cnt);
    half_ev = p_rise & pos_valid & ((pos == 11'h000) | (pos == half_cnt));
    next_hcnt = p_rise ? pos : hcnt;
    // vertical signals start from the first selected sync of a frame
    vref[0] = hs_rise & (vpend[0] | vs_rise);
    vref[1] = off_ev & (vpend[1] | vs_rise);
    next_vpend = vs_rise ? 2'h3 : vpend;
    next_vpend = next_vpend & ~vref;
    next_line_pos = vs_rise ? 11'h000 : (hs_rise ? line_pos + 11'h001 : line_pos);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_last <= 1'b0;
      hs_last <= 1'b0;
      vs_last <= 1'b0;
      hcnt <= 11'h7ff;
      vpend <= 2'h0;
      line_pos <= `COUNT_RESET;
    end else begin
      clk_last <= next_clk_last;
      hs_last <= next_hs_last;
      vs_last <= next_vs_last;
      hcnt <= next_hcnt;
      vpend <= next_vpend;
      line_pos <= next_line_pos;
    end
  end

  // eight generators; signals 0 and 1 are vertical
  logic [NUM_SIG-1:0] gen_level, launch, next_launch;
  for (genvar i = 0; i < NUM_SIG; i++) begin : g_sig
    localparam bit VERT = (i < 2);
    logic tick_i, ref_i;
    always_comb begin
      tick_i = VERT ? half_ev : p_rise;
      if (VERT) begin
        ref_i = cfg[i].refsel ? vref[1] : vref[0];
      end else begin
        ref_i = cfg[i].refsel ? off_ev : hs_rise;
      end
    end
    tcon_pulse_gen #(
      .IS_POL(i == SIG_POL_A || i == SIG_POL_B),
      .USE_START(i != SIG_DE),
      .CW(11)
    ) u_gen (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_i),
      .ref_ev(ref_i),
      .frame_ev(vs_rise),
      .cfg(cfg[i]),
      .level(gen_level[i])
    );
  end

  // launch each signal on its chosen panel clock edge, with its polarity
  always_comb begin
    for (int i = 0; i < NUM_SIG; i++) begin
      next_launch[i] = launch[i];
      if (cfg[i].fall_edge ? p_fall : p_rise) begin
        next_launch[i] = gen_level[i] ^ cfg[i].inv;
      end
    end
  end

  // pin routing; a pin with several sources shows their OR
  logic [NUM_PIN-1:0] next_pins;
  always_comb begin
    for (int p = 0; p < NUM_PIN; p++) begin
      next_pins[p] = 1'b0;
      for (int i = 0; i < NUM_SIG; i++) begin
        if (cfg[i].pin == 4'(p)) begin
          next_pins[p] = next_pins[p] | launch[i];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launch <= '0;
      panel_timing_out_pin <= 7'h00;
    end else begin
      launch <= next_launch;
      panel_timing_out_pin <= next_pins;
    end
  end

  // line position match: fires once when a position changes onto the compare value
  function automatic logic line_hit(input logic [10:0] prev, input logic [10:0] cur,
                                    input logic [10:0] cmp);
    line_hit = (cur != prev) && (cur == cmp);
  endfunction

  logic [10:0] s0_prev, s1_prev, oi_prev;
  always_comb begin
    line_ev[0] = line_hit(line_pos, next_line_pos, line_cmp);
    line_ev[1] = line_hit(s0_prev, scaler0_line, line_cmp);
    line_ev[2] = line_hit(s1_prev, scaler1_line, line_cmp);
    line_ev[3] = line_hit(oi_prev, out_image_line, line_cmp);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s0_prev <= `COUNT_RESET;
      s1_prev <= `COUNT_RESET;
      oi_prev <= `COUNT_RESET;
    end else begin
      s0_prev <= scaler0_line;
      s1_prev <= scaler1_line;
      oi_prev <= out_image_line;
    end
  end

  // signal register decode: {hit, index, control word}
  function automatic logic [4:0] sig_decode(input logic [11:0] addr);
    logic [11:0] off;
    off = addr - `SIG_BASE_ADDR;
    sig_decode = {(addr >= `SIG_BASE_ADDR) && (off < `SIG_SPAN) && (addr[1:0] == 2'h0),
                  off[5:3], off[2]};
  endfunction

  // read multiplexer: {valid, data}
  function automatic logic [32:0] read_word(input logic [11:0] addr);
    logic [4:0] dec;
    logic [31:0] d;
    dec = sig_decode(addr);
    d = 32'h0000_0000;
    read_word = {1'b1, d};
    if (dec[4]) begin
      if (dec[0]) begin
        d[`MODE_LSB +: 2] = cfg[dec[3:1]].mode;
        d[`REFSEL_BIT] = cfg[dec[3:1]].refsel;
        d[`INV_BIT] = cfg[dec[3:1]].inv;
        d[`PIN_LSB +: 4] = cfg[dec[3:1]].pin;
        d[`EDGE_BIT] = cfg[dec[3:1]].fall_edge;
      end else begin
        d[`START_LSB +: 11] = cfg[dec[3:1]].start;
        d[`WIDTH_LSB +: 11] = cfg[dec[3:1]].width;
      end
      read_word = {1'b1, d};
    end else begin
      case (addr)
        `HALF_LINE_ADDR: read_word = {1'b1, 21'h000000, half_cnt};
        `OFFSET_HS_ADDR: read_word = {1'b1, 21'h000000, offset_cnt};
        `LINE_CMP_ADDR: read_word = {1'b1, 21'h000000, line_cmp};
        `IRQ_STATUS_ADDR: read_word = {1'b1, 28'h0000000, irq_status};
        `IRQ_ENABLE_ADDR: read_word = {1'b1, 28'h0000000, irq_enable};
        `LINE_POS_ADDR: read_word = {1'b1, 21'h000000, line_pos};
        default: read_word = {1'b0, 32'h0000_0000};
      endcase
    end
  endfunction

  // register writes and interrupt status
  logic wr;
  logic [4:0] wdec;
  logic [32:0] rword;
  always_comb begin
    wr = psel & penable & pwrite;
    rword = read_word(paddr);
    wdec = sig_decode(paddr);
    next_cfg = cfg;
    next_half_cnt = half_cnt;
    next_offset_cnt = offset_cnt;
    next_line_cmp = line_cmp;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    if (wr && wdec[4] && wdec[0]) begin
      next_cfg[wdec[3:1]].mode = pwdata[`MODE_LSB +: 2];
      next_cfg[wdec[3:1]].refsel = pwdata[`REFSEL_BIT];
      next_cfg[wdec[3:1]].inv = pwdata[`INV_BIT];
      next_cfg[wdec[3:1]].pin = pwdata[`PIN_LSB +: 4];
      next_cfg[wdec[3:1]].fall_edge = pwdata[`EDGE_BIT];
    end else if (wr && wdec[4]) begin
      next_cfg[wdec[3:1]].start = pwdata[`START_LSB +: 11];
      next_cfg[wdec[3:1]].width = pwdata[`WIDTH_LSB +: 11];
    end else if (wr) begin
      case (paddr)
        `HALF_LINE_ADDR: next_half_cnt = pwdata[10:0];
        `OFFSET_HS_ADDR: next_offset_cnt = pwdata[10:0];
        `LINE_CMP_ADDR: next_line_cmp = pwdata[10:0];
        `IRQ_STATUS_ADDR: next_irq_status = irq_status & ~pwdata[3:0];
        `IRQ_ENABLE_ADDR: next_irq_enable = pwdata[3:0];
        default: next_irq_status = irq_status;
      endcase
    end
    next_irq_status = next_irq_status | line_ev; // set wins over clear
    // read data and error are captured in the setup cycle
    {next_pslverr, next_prdata} = {pslverr, prdata};
    if (psel && !penable) begin
      next_pslverr = ~rword[32];
      next_prdata = pwrite ? 32'h0000_0000 : rword[31:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_SIG; i++) begin
        cfg[i] <= '{start: `COUNT_RESET, width: `COUNT_RESET, mode: 2'h0, refsel: 1'b0,
                    inv: 1'b0, pin: `PIN_NONE, fall_edge: 1'b0};
      end
      half_cnt <= `COUNT_RESET;
      offset_cnt <= `COUNT_RESET;
      line_cmp <= `COUNT_RESET;
      irq_status <= `IRQ_RESET;
      irq_enable <= `IRQ_RESET;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      half_cnt <= next_half_cnt;
      offset_cnt <= next_offset_cnt;
      line_cmp <= next_line_cmp;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign pready = 1'b1;
  assign irq = |(irq_status & irq_enable);

  // panel clocks since the last normal sync, for the checks only
  logic [11:0] clocks_since_hs;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clocks_since_hs <= 12'hfff;
    end else if (hs_rise) begin
      clocks_since_hs <= 12'h000;
    end else if (p_rise && clocks_since_hs != 12'hfff) begin
      clocks_since_hs <= clocks_since_hs + 12'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_offset_sync_pos: assert property ((off_ev && !hs_rise) |->
    clocks_since_hs + 12'h001 == {1'b0, offset_cnt})
    else $error("offset sync fired at the wrong panel clock");
  chk_display_line: assert property (line_ev[0] |=> irq_status[0] && line_pos == line_cmp)
    else $error("display line match did not set its status");
  chk_scaler_line: assert property (($changed(scaler0_line) && scaler0_line == line_cmp)
    |=> irq_status[1])
    else $error("scaler line match did not set its status");
  chk_irq_enable: assert property ((irq_enable == 4'h0) [*2] |-> !irq)
    else $error("interrupt delivered with every enable clear");
  chk_no_stray_irq: assert property ((!irq && irq_status == 4'h0 && line_ev == 4'h0)
    |=> !irq)
    else $error("interrupt raised without a line match");
  for (genvar i = 0; i < NUM_SIG; i++) begin : g_chk
    chk_launch_edge: assert property ($changed(launch[i]) |->
      $past(cfg[i].fall_edge ? p_fall : p_rise))
      else $error("signal changed away from its launch edge");
    chk_launch_level: assert property ((p_rise && !cfg[i].fall_edge) |=>
      launch[i] == $past(gen_level[i] ^ cfg[i].inv))
      else $error("launched level ignores the inversion setting");
  end
  for (genvar p = 0; p < NUM_PIN; p++) begin : g_pin_chk
    logic routed;
    always_comb begin
      routed = 1'b0;
      for (int i = 0; i < NUM_SIG; i++) begin
        routed = routed | (cfg[i].pin == 4'(p));
      end
    end
    chk_unrouted_pin: assert property (!routed [*2] |-> !panel_timing_out_pin[p])
      else $error("pin driven with no signal routed to it");
  end
  cov_offset_ref: cover property (off_ev && cfg[2].refsel);
  cov_line_irq: cover property ($rose(irq));
  cov_falling_launch: cover property (p_fall && cfg[0].fall_edge && gen_level[0]);

endmodule

// ---- panel_timing_signal_gen_tb.sv ----
// Purpose: self-checking bench of the panel timing generator
// Assumes: one 64 ns panel clock is 12.8 pclk cycles
// Notes: pulse edges are timed in pclk cycles from the sync pin rise
`timescale 1ns/100ps
`include "panel_timing_params.svh"
module panel_timing_signal_gen_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [10:0] sl0 = 11'h000;
  logic [10:0] sl1 = 11'h000;
  logic [10:0] oil = 11'h000;
  logic [31:0] prdata;
  logic [31:0] q;
  logic [6:0] pin;
  logic pready, pslverr, panel_clk, hsync_in, vsync_in, irq, e;
  int err_count = 0;
  int n_checks = 0;
  int r1, f1, r2, f2;

  // 200 MHz bus clock
  always #2.5 pclk = ~pclk;

  panel_timing_signal_gen i_panel_timing_signal_gen (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .panel_clk(panel_clk),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .scaler0_line(sl0), .scaler1_line(sl1),
    .out_image_line(oil), .panel_timing_out_pin(pin), .irq(irq));
  panel_side_model i_panel_side_model (.panel_clk(panel_clk), .hsync_in(hsync_in),
    .vsync_in(vsync_in));

  task automatic results();
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // a cycle count must sit within tol of ex
  task automatic near(input string nm, input int ex, input int got, input int tol);
    chk(nm, 32'(ex), 32'((got > ex - tol && got < ex + tol) ? ex : got));
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following transfer never re-drives psel in the same step
    @(posedge pclk);
  endtask

  function automatic logic [11:0] sa(input int n, input int k);
    return `SIG_BASE_ADDR + 12'(8 * n + 4 * k);
  endfunction

  task automatic cfg(input int n, input logic [31:0] tm, input logic [31:0] ct);
    apb(1'b1, sa(n, 0), tm);
    apb(1'b1, sa(n, 1), ct);
  endtask

  // first change away from idle and return, over one line or, for long spans, one frame
  task automatic meas(input int p, input logic idle, output int r, output int f,
                      input int len = 500);
    int c;
    r = -1;
    f = -1;
    if (len > 500) begin
      @(posedge vsync_in);
    end else begin
      @(posedge hsync_in);
    end
    for (c = 0; c < len; c++) begin
      @(posedge pclk);
      if (r < 0 && pin[p] !== idle) r = c;
      if (r >= 0 && f < 0 && pin[p] === idle) f = c;
    end
  endtask

  task automatic t_regs();
    apb(1'b0, sa(3, 1), 32'h0);
    chk("ctrl reset", 32'h0000_00f0, q);
    apb(1'b0, sa(3, 0), 32'h0);
    chk("timing reset", 32'h0, q);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped err", 32'h1, e);
    chk("unmapped data", 32'h0, q);
    apb(1'b1, `LINE_POS_ADDR, 32'h7ff);
    chk("read-only write err", 32'h0, e);
  endtask

  task automatic t_horiz();
    cfg(2, 32'h0005_0003, 32'h0);
    repeat (2) meas(0, 1'b0, r1, f1);
    near("pulse width", 64, f1 - r1, 4);
    cfg(2, 32'h0005_0009, 32'h0);
    repeat (2) meas(0, 1'b0, r2, f2);
    near("start step", 77, r2 - r1, 4);
    apb(1'b1, `OFFSET_HS_ADDR, 32'h4);
    apb(1'b1, sa(2, 1), 32'h04);
    repeat (2) meas(0, 1'b0, r1, f1);
    near("offset reference", 51, r1 - r2, 4);
    apb(1'b1, sa(2, 1), 32'h100);
    repeat (2) meas(0, 1'b0, r1, f1);
    near("falling launch", 6, (r2 > r1) ? r2 - r1 : r1 - r2, 3);
    apb(1'b1, sa(2, 1), 32'h68);
    repeat (2) meas(6, 1'b1, r1, f1);
    near("inverted width", 64, f1 - r1, 4);
    chk("pin routing", 32'h40, pin);
    apb(1'b1, sa(2, 1), 32'hf0);
  endtask

  // vertical signal counted in half lines, half line at 20 panel clocks
  task automatic t_vert();
    apb(1'b1, `HALF_LINE_ADDR, 32'h14);
    cfg(0, 32'h0003_0002, 32'h20);
    repeat (2) meas(2, 1'b0, r1, f1, 3000);
    near("vertical width", 768, f1 - r1, 4);
    apb(1'b1, sa(0, 0), 32'h0003_0003);
    repeat (2) meas(2, 1'b0, r2, f2, 3000);
    near("vertical start", 256, r2 - r1, 4);
    apb(1'b1, sa(0, 1), 32'hf0);
  endtask

  task automatic t_de();
    cfg(7, 32'h0004_0000, 32'h0);
    repeat (2) meas(0, 1'b0, r1, f1);
    cfg(7, 32'h0004_0014, 32'h0);
    repeat (2) meas(0, 1'b0, r2, f2);
    near("data enable start", 0, r2 - r1, 3);
    apb(1'b1, sa(7, 1), 32'hf0);
  endtask

  task automatic t_pol();
    int m, c, n;
    logic lv;
    for (m = 0; m < 4; m++) begin
      cfg(5, 32'h0000_0001, 32'h10 | m);
      repeat (2) @(posedge vsync_in);
      n = 0;
      lv = pin[1];
      for (c = 0; c < 3000; c++) begin
        @(posedge pclk);
        if (pin[1] !== lv) n++;
        lv = pin[1];
      end
      chk("polarity flips", (m < 2) ? 6 : 3, n);
    end
    apb(1'b1, sa(5, 1), 32'hf0);
  endtask

  task automatic t_irq();
    int b;
    apb(1'b1, `LINE_CMP_ADDR, 32'h3);
    apb(1'b1, `IRQ_ENABLE_ADDR, 32'h0);
    @(posedge vsync_in);
    @(posedge pclk);
    apb(1'b1, `IRQ_STATUS_ADDR, 32'hf);
    apb(1'b0, `IRQ_STATUS_ADDR, 32'h0);
    chk("status clear", 32'h0, q);
    repeat (5) @(posedge hsync_in);
    repeat (30) @(posedge pclk);
    apb(1'b0, `IRQ_STATUS_ADDR, 32'h0);
    chk("line status", 32'h1, q);
    chk("masked irq", 32'h0, irq);
    apb(1'b1, `IRQ_ENABLE_ADDR, 32'h1);
    @(posedge pclk);
    chk("irq raised", 32'h1, irq);
    apb(1'b1, `IRQ_STATUS_ADDR, 32'h1);
    @(posedge pclk);
    chk("irq cleared", 32'h0, irq);
    for (b = 1; b < 4; b++) begin
      apb(1'b1, `IRQ_ENABLE_ADDR, 32'(1 << b));
      sl0 <= (b == 1) ? 11'h003 : 11'h002;
      sl1 <= (b == 2) ? 11'h003 : 11'h002;
      oil <= (b == 3) ? 11'h003 : 11'h002;
      repeat (3) @(posedge pclk);
      chk("scaler irq", 32'h1, irq);
      apb(1'b0, `IRQ_STATUS_ADDR, 32'h0);
      chk("scaler status", 32'(1 << b), q & 32'he);
      apb(1'b1, `IRQ_STATUS_ADDR, 32'hf);
      @(posedge pclk);
      chk("scaler cleared", 32'h0, irq);
    end
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_horiz();
    t_vert();
    t_de();
    t_pol();
    t_irq();
    results();
  end

  // cuts a hang short; the scenarios need about 49000 cycles
  initial begin
    #450000;
    err_count++;
    results();
  end
endmodule

// ---- tcon_pulse_gen.sv ----
// Purpose: one programmable timing pulse with start delay, width and polarity pattern
// Assumes: tick, ref_ev and frame_ev are one-cycle strobes on pclk
// Notes: ref_ev restarts the sequence even while a pulse is still running
`timescale 1ns/100ps
`include "panel_timing_params.svh"
module tcon_pulse_gen
  import panel_timing_pkg::*;
#(
  parameter bit IS_POL = 1'b0,
  parameter bit USE_START = 1'b1,
  parameter int CW = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic ref_ev,
  input wire logic frame_ev,
  input wire sig_cfg_t cfg,
  output logic level
);

  localparam logic [CW-1:0] ONE = CW'(1);

  if (CW != $bits(cfg.start)) begin : g_bad_width
    $error("counter width must match the 11-bit start and width fields");
  end

  pulse_state_t state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic pol, next_pol;
  logic lidx, next_lidx;
  logic hit;

  // flip decision of the polarity pattern for the current line parity
  function automatic logic pol_flip(input logic [1:0] mode, input logic odd_line);
    case (mode)
      2'h2: pol_flip = ~odd_line; // first line, then every second line
      2'h3: pol_flip = odd_line;  // every second line
      default: pol_flip = 1'b1;   // every line
    endcase
  endfunction

  // start delay and width counting
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    hit = 1'b0;
    if (ref_ev) begin
      if (USE_START && cfg.start != `COUNT_RESET) begin
        next_state = PS_WAIT;
        next_cnt = cfg.start;
      end else begin
        hit = 1'b1;
      end
    end else begin
      case (state)
        PS_WAIT: begin
          if (tick) begin
            if (cnt == ONE) begin
              hit = 1'b1;
            end else begin
              next_cnt = cnt - ONE;
            end
          end
        end
        PS_PULSE: begin
          if (tick) begin
            if (cnt == ONE) begin
              next_state = PS_IDLE;
            end else begin
              next_cnt = cnt - ONE;
            end
          end
        end
        default: begin
          next_state = PS_IDLE;
        end
      endcase
    end
    if (hit) begin
      next_state = (cfg.width != `COUNT_RESET) ? PS_PULSE : PS_IDLE;
      next_cnt = cfg.width;
    end
  end

  // polarity pattern, stepped once per line at the start position
  always_comb begin
    next_pol = pol;
    next_lidx = lidx;
    if (frame_ev) begin
      next_lidx = 1'b0;
    end
    // a start of at least one keeps the frame restart apart from the flip
    if (hit) begin
      if (pol_flip(cfg.mode, lidx)) begin
        next_pol = ~pol;
      end
      next_lidx = ~lidx;
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PS_IDLE;
      cnt <= `COUNT_RESET;
      pol <= 1'b0;
      lidx <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pol <= next_pol;
      lidx <= next_lidx;
    end
  end

  assign level = IS_POL ? pol : (state == PS_PULSE);

  // ticks seen since the last reference, for the checks only
  logic [CW:0] ticks_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ticks_seen <= '0;
    end else if (ref_ev) begin
      ticks_seen <= '0;
    end else if (tick && ticks_seen != '1) begin
      ticks_seen <= ticks_seen + (CW+1)'(1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_start_delay: assert property ($rose(state == PS_PULSE) |->
    ticks_seen == (USE_START ? {1'b0, cfg.start} : '0))
    else $error("pulse began at the wrong count after the reference");
  chk_pulse_width: assert property (($fell(state == PS_PULSE) && !$past(ref_ev)) |->
    ticks_seen == (USE_START ? {1'b0, cfg.start} : '0) + {1'b0, cfg.width})
    else $error("pulse lasted the wrong number of ticks");
  chk_de_no_start: assert property ((!USE_START && ref_ev && cfg.width != '0) |=>
    state == PS_PULSE)
    else $error("start-less signal did not begin at its reference");
  chk_pol_skip: assert property ((hit && cfg.mode == 2'h3 && !lidx) |=> $stable(pol))
    else $error("polarity flipped on a line the pattern skips");
  chk_pol_cause: assert property ($changed(pol) |-> $past(hit))
    else $error("polarity changed away from the start position");
  cov_pulse_done: cover property ($fell(state == PS_PULSE));
  cov_pol_flip: cover property (IS_POL && $changed(pol));

endmodule
